// ==== pkg/ctm_defs.vh ====
//----------------------------------------------------------------------
// Function
// - 10-bit up-counter advancing on the clock chosen by clock_select
// - period_value compared with count bits 9..7, compare_value with all bits
// - software cannot load count; run_control rising edge zeroes it
// - counter clears on overflow or selected match, raising match events
// - run_control low stops counting and keeps the count
// - counter_pause high holds the count; counting resumes when low
// - clock_select codes pick sys/4, sys, high/16, high/64, tbc, pin edges
// - undefined clock_select code gives no clock; counter stops
// - compare output mode: run_control rise restores output_initial_level
// - period_field step is 128 clocks; code 000 means 1024 clocks
// - clear_select zero clears counter on period match outside PWM mode
// - period_field zero lets counter run to maximum and overflow
// - count pair read-only, bits 9..8 in high byte, upper bits zero
// - compare pair read/write, bits 9..8 in high byte, reset zero
// - timer output drives two pins, same signal or inverse
// - modes: compare-match output, timer/counter, PWM output
// - low byte write goes to buffer; high byte write moves both
// - high byte read latches low byte into buffer for next read
// - mode_field: 00 compare output, 10 PWM, 11 timer, 01 undefined
// - clear_select one clears counter on compare match outside PWM mode
//----------------------------------------------------------------------
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH

// register byte offsets
`define CTM_OFS_CTRL0 8'h00
`define CTM_OFS_CTRL1 8'h04
`define CTM_OFS_CNTL 8'h08
`define CTM_OFS_CNTH 8'h0c
`define CTM_OFS_CMPL 8'h10
`define CTM_OFS_CMPH 8'h14
`define CTM_OFS_PINS 8'h18

// control zero fields
`define CTM_C0_PAUSE 7
`define CTM_C0_CKS_HI 6
`define CTM_C0_CKS_LO 4
`define CTM_C0_RUN 3
`define CTM_C0_PER_HI 2
`define CTM_C0_PER_LO 0

// control one fields
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_IO_HI 5
`define CTM_C1_IO_LO 4
`define CTM_C1_OC 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CCLR 0

// pin control fields
`define CTM_PIN_A_EN 0
`define CTM_PIN_B_EN 1
`define CTM_PIN_B_INV 2

// reset values
`define CTM_RST_CTRL0 8'h00
`define CTM_RST_CTRL1 8'h00
`define CTM_RST_PINS 8'h00

// clock select codes
`define CTM_CK_SYS4 3'h0
`define CTM_CK_SYS 3'h1
`define CTM_CK_H16 3'h2
`define CTM_CK_H64 3'h3
`define CTM_CK_TBC 3'h4
`define CTM_CK_RISE 3'h6
`define CTM_CK_FALL 3'h7

// mode codes
`define CTM_MODE_CMP 2'h0
`define CTM_MODE_PWM 2'h2
`define CTM_MODE_TMR 2'h3

// output action codes
`define CTM_IO_NONE 2'h0
`define CTM_IO_LOW 2'h1
`define CTM_IO_HIGH 2'h2
`define CTM_IO_TOG 2'h3

// prescaler taps
`define CTM_DIV4_MASK 6'h03
`define CTM_DIV16_MASK 6'h0f
`define CTM_DIV64_MASK 6'h3f

// counter geometry
`define CTM_CNT_MAX 10'h3ff
`define CTM_PER_SHIFT 7

`endif

// ==== hw/ctm_timer.v ====
// Design decisions made here: the APB slave port and the register addresses.
`include "ctm_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ctm_timer
(
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // apb slave
  input wire [7:0] paddr_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // clock sources
  input wire tbc_tick_in,
  input wire ext_clk_in,
  // timer pins
  output reg pin_a_out,
  output reg pin_a_oe_out,
  output reg pin_b_out,
  output reg pin_b_oe_out,
  // match events
  output reg period_match_out,
  output reg compare_match_out
);

  //--------------------------------------------------------------------
  // registers and state
  //--------------------------------------------------------------------
  reg [7:0] ctrl0_r;
  reg [7:0] ctrl1_r;
  reg [7:0] pins_r;
  reg [9:0] compare_r;
  reg [7:0] hold_buf_r;
  reg [9:0] count_r;
  reg [9:0] count_nxt;
  reg [5:0] presc_r;
  reg ext_prev_r;
  reg level_r;
  reg level_nxt;
  reg tick;
  reg clr_hit;
  reg pmatch;
  reg amatch;
  reg pwm_act;
  reg [31:0] rd_mux;
  reg addr_ok;

  //--------------------------------------------------------------------
  // field views
  //--------------------------------------------------------------------
  wire counter_pause = ctrl0_r[`CTM_C0_PAUSE];
  wire [2:0] clock_select = ctrl0_r[`CTM_C0_CKS_HI:`CTM_C0_CKS_LO];
  wire run_control = ctrl0_r[`CTM_C0_RUN];
  wire [2:0] period_field = ctrl0_r[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
  wire [1:0] mode_field = ctrl1_r[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
  wire [1:0] io_field = ctrl1_r[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
  wire output_initial_level = ctrl1_r[`CTM_C1_OC];
  wire out_invert = ctrl1_r[`CTM_C1_POL];
  wire duty_swap = ctrl1_r[`CTM_C1_DPX];
  wire clear_select = ctrl1_r[`CTM_C1_CCLR];

  //--------------------------------------------------------------------
  // apb decode
  //--------------------------------------------------------------------
  // access edge: the master sees pready high at this edge
  wire acc = psel_in & penable_in & pready_out;
  wire wr_acc = acc & pwrite_in;
  wire rd_acc = acc & ~pwrite_in;
  wire wr_c0 = wr_acc & (paddr_in == `CTM_OFS_CTRL0);
  wire run_rise = wr_c0 & pwdata_in[`CTM_C0_RUN] & ~run_control;

  // read data and address check, one wait state before pready
  always @*
  begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr_in)
      `CTM_OFS_CTRL0: rd_mux[7:0] = ctrl0_r;
      `CTM_OFS_CTRL1: rd_mux[7:0] = ctrl1_r;
      `CTM_OFS_CNTL: rd_mux[7:0] = hold_buf_r;
      `CTM_OFS_CNTH: rd_mux[1:0] = count_r[9:8];
      `CTM_OFS_CMPL: rd_mux[7:0] = hold_buf_r;
      `CTM_OFS_CMPH: rd_mux[1:0] = compare_r[9:8];
      `CTM_OFS_PINS: rd_mux[7:0] = pins_r;
      default: addr_ok = 1'b0;
    endcase
  end

  // bus handshake outputs
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
    else if (psel_in & penable_in & ~pready_out)
    begin
      pready_out <= 1'b1;
      pslverr_out <= ~addr_ok;
      prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // register writes and holding buffer
  //--------------------------------------------------------------------
  // the count pair has no write path at all
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ctrl0_r <= `CTM_RST_CTRL0;
      ctrl1_r <= `CTM_RST_CTRL1;
      pins_r <= `CTM_RST_PINS;
      compare_r <= 10'h000;
      hold_buf_r <= 8'h00;
    end
    else if (wr_acc)
    begin
      case (paddr_in)
        `CTM_OFS_CTRL0: ctrl0_r <= pwdata_in[7:0];
        `CTM_OFS_CTRL1: ctrl1_r <= pwdata_in[7:0];
        `CTM_OFS_PINS: pins_r <= pwdata_in[7:0];
        `CTM_OFS_CMPL: hold_buf_r <= pwdata_in[7:0];
        `CTM_OFS_CMPH: compare_r <= {pwdata_in[1:0], hold_buf_r};
        default: ;
      endcase
    end
    else if (rd_acc)
    begin
      case (paddr_in)
        `CTM_OFS_CNTH: hold_buf_r <= count_r[7:0];
        `CTM_OFS_CMPH: hold_buf_r <= compare_r[7:0];
        default: ;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // clock source selection
  //--------------------------------------------------------------------
  // free prescaler; system and high clock both equal clk_in here
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      presc_r <= 6'h00;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      presc_r <= presc_r + 6'h01;
      ext_prev_r <= ext_clk_in;
    end
  end

  // one-cycle count enable from the chosen source
  always @*
  begin
    case (clock_select)
      `CTM_CK_SYS4: tick = (presc_r & `CTM_DIV4_MASK) == `CTM_DIV4_MASK;
      `CTM_CK_SYS: tick = 1'b1;
      `CTM_CK_H16: tick = (presc_r & `CTM_DIV16_MASK) == `CTM_DIV16_MASK;
      `CTM_CK_H64: tick = (presc_r & `CTM_DIV64_MASK) == `CTM_DIV64_MASK;
      `CTM_CK_TBC: tick = tbc_tick_in;
      `CTM_CK_RISE: tick = ext_clk_in & ~ext_prev_r;
      `CTM_CK_FALL: tick = ~ext_clk_in & ext_prev_r;
      default: tick = 1'b0;
    endcase
  end

  //--------------------------------------------------------------------
  // comparators and clear condition
  //--------------------------------------------------------------------
  // matches look at the value the counter is about to reach
  always @*
  begin
    count_nxt = count_r + 10'h001;
    pmatch = (period_field != 3'h0) &&
      (count_nxt[9:`CTM_PER_SHIFT] == period_field);
    amatch = (count_nxt == compare_r);
    if (mode_field == `CTM_MODE_PWM)
      clr_hit = duty_swap ? amatch : pmatch;
    else if (clear_select)
      clr_hit = amatch;
    else
      clr_hit = pmatch;
    // code 000 leaves only the wrap at maximum
    if (count_r == `CTM_CNT_MAX)
      clr_hit = 1'b1;
  end

  //--------------------------------------------------------------------
  // counter
  //--------------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
      count_r <= 10'h000;
    else if (run_rise)
      count_r <= 10'h000;
    else if (run_control & ~counter_pause & tick)
      count_r <= clr_hit ? 10'h000 : count_nxt;
  end

  // match event pulses toward the interrupt controller
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      period_match_out <= 1'b0;
      compare_match_out <= 1'b0;
    end
    else
    begin
      period_match_out <= run_control & ~counter_pause & tick &
        (pmatch | ((period_field == 3'h0) &&
        (count_r == `CTM_CNT_MAX)));
      compare_match_out <= run_control & ~counter_pause & tick &
        amatch;
    end
  end

  //--------------------------------------------------------------------
  // output level generation
  //--------------------------------------------------------------------
  // pwm active while count is below duty
  always @*
  begin
    if (duty_swap)
      pwm_act = count_r[9:`CTM_PER_SHIFT] < period_field;
    else
      pwm_act = count_r < compare_r;
  end

  // level before polarity, per mode
  always @*
  begin
    level_nxt = level_r;
    case (mode_field)
      `CTM_MODE_CMP:
      begin
        if (run_rise)
          level_nxt = output_initial_level;
        else if (run_control & ~counter_pause & tick & amatch)
        begin
          case (io_field)
            `CTM_IO_LOW: level_nxt = 1'b0;
            `CTM_IO_HIGH: level_nxt = 1'b1;
            `CTM_IO_TOG: level_nxt = ~level_r;
            default: level_nxt = level_r;
          endcase
        end
      end
      `CTM_MODE_PWM:
      begin
        case (io_field)
          `CTM_IO_NONE: level_nxt = ~output_initial_level;
          `CTM_IO_LOW: level_nxt = output_initial_level;
          `CTM_IO_HIGH: level_nxt = pwm_act ? output_initial_level :
            ~output_initial_level;
          default: level_nxt = level_r;
        endcase
      end
      default: level_nxt = level_r;
    endcase
  end

  always @(posedge clk_in)
  begin
    if (!rst_n_in)
      level_r <= 1'b0;
    else
      level_r <= level_nxt;
  end

  //--------------------------------------------------------------------
  // pin drivers
  //--------------------------------------------------------------------
  // timer mode leaves both pins undriven
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      pin_a_out <= 1'b0;
      pin_b_out <= 1'b0;
      pin_a_oe_out <= 1'b0;
      pin_b_oe_out <= 1'b0;
    end
    else
    begin
      pin_a_out <= level_r ^ out_invert;
      pin_b_out <= level_r ^ out_invert ^ pins_r[`CTM_PIN_B_INV];
      pin_a_oe_out <= pins_r[`CTM_PIN_A_EN] &
        (mode_field != `CTM_MODE_TMR);
      pin_b_oe_out <= pins_r[`CTM_PIN_B_EN] &
        (mode_field != `CTM_MODE_TMR);
    end
  end

endmodule

`default_nettype wire

// ==== sim/ctm_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ctm_pin_model
(
  // system clock
  input wire logic clk_in,
  // external clock pin, idle low between bursts
  output logic ext_clk_out
);
  initial ext_clk_out = 1'b0;

  // whole pulses, each level held four clocks so sync sees it
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_in);
      ext_clk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      ext_clk_out <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// ==== sim/ctm_timer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module ctm_timer_checker
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // bus side
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // events
  input wire logic period_match_out,
  input wire logic compare_match_out
);
  // ----------------------------------------
  // answer and event checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // one wait state, single-cycle answer
  ready_wait_a: assert property ($rose(penable_in) && psel_in |=> pready_out)
    else $error("ready late");
  ready_cause_a: assert property (pready_out |->
    psel_in && penable_in && $past(penable_in)) else $error("stray ready");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready held");
  // address decode
  err_range_a: assert property (pready_out && paddr_in > 8'h18 |->
    pslverr_out) else $error("unmapped not refused");
  ok_range_a: assert property (pready_out && paddr_in <= 8'h18 &&
    paddr_in[1:0] == 2'h0 |-> !pslverr_out) else $error("mapped refused");
  err_zero_a: assert property (pslverr_out && !pwrite_in |->
    prdata_out == 32'h0) else $error("refused read not zero");
  // unused high-byte bits read zero
  hi_count_a: assert property (pready_out && !pwrite_in &&
    paddr_in == 8'h0c |-> prdata_out[31:2] == 30'h0) else $error("cnt hi");
  hi_cmp_a: assert property (pready_out && !pwrite_in &&
    paddr_in == 8'h14 |-> prdata_out[31:2] == 30'h0) else $error("cmp hi");
  // period match pulses are at least nine cycles apart
  period_gap_a: assert property (period_match_out |=>
    !period_match_out [*8]) else $error("period pulses too close");

  cover property (pslverr_out);
  cover property (period_match_out);
  cover property (compare_match_out);
endmodule

`default_nettype wire

// ==== sim/compact_timer_module_tb.sv ====
`timescale 1ns/1ps
`include "ctm_defs.vh"
`default_nettype none

module compact_timer_module_tb;
  // ----------------------------------------
  // bench state
  // ----------------------------------------
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] pwdata_in = 32'h0;
  logic tbc_tick_in = 1'b0;
  wire ext_clk_in;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, pin_a_out, pin_a_oe_out, pin_b_out;
  wire pin_b_oe_out, period_match_out, compare_match_out;
  logic [31:0] rd;
  logic er;
  logic [9:0] c1, c2;
  int pw;
  int err_total = 0;
  int num_checks = 0;
  int ck[5] = '{1, 0, 2, 3, 4};
  int gp[5] = '{128, 512, 2048, 8192, 256};
  logic [7:0] fz[3] = '{8'h98, 8'h10, 8'h58};

  ctm_timer dut (.*);
  ctm_pin_model pin (.clk_in(clk_in), .ext_clk_out(ext_clk_in));

  // clock and a time-base tick every other cycle
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) tbc_tick_in <= ~tbc_tick_in;

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // one bus transfer; waits for the answer, idles one cycle after
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    psel_in <= 1'b1;
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= {24'h0, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    // look at pready mid-cycle, then complete on the next rising edge
    do
      @(negedge clk_in);
    while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    @(posedge clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, e);
    apb(a, 1'b0, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask

  // high byte first so the low byte comes from the same snapshot
  task automatic rcnt(output logic [9:0] c);
    apb(8'h0c, 1'b0, 8'h00);
    c[9:8] = rd[1:0];
    apb(8'h08, 1'b0, 8'h00);
    c[7:0] = rd[7:0];
  endtask

  // cycles between two successive event pulses
  task automatic gap(input logic s, input int e, input string nm);
    int n;
    n = 0;
    @(negedge clk_in);
    while ((s ? compare_match_out : period_match_out) !== 1'b1)
      @(negedge clk_in);
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while ((s ? compare_match_out : period_match_out) !== 1'b1);
    chk(nm, e, n);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rdc("ctrl0", 8'h00, 8'h00);
    rdc("ctrl1", 8'h04, 8'h00);
    apb(8'h40, 1'b0, 8'h00);
    chk("slverr", 32'h1, {31'h0, er});
    apb(8'h0c, 1'b1, 8'hff);
    rdc("cnt_hi", 8'h0c, 8'h00);
    apb(8'h10, 1'b1, 8'h5a);
    rdc("cmp_hi", 8'h14, 8'h00);
    rdc("cmp_lo", 8'h10, 8'h00);
    apb(8'h10, 1'b1, 8'ha5);
    apb(8'h14, 1'b1, 8'hff);
    rdc("cmp_hi", 8'h14, 8'h03);
    rdc("cmp_lo", 8'h10, 8'ha5);
    for (int i = 0; i < 5; i++)
    begin
      apb(8'h00, 1'b1, {1'b0, ck[i][2:0], 4'h9});
      gap(1'b0, gp[i], "ck_gap");
    end
    apb(8'h00, 1'b1, 8'h18);
    gap(1'b0, 1024, "ovf");
    apb(8'h10, 1'b1, 8'h09);
    apb(8'h14, 1'b1, 8'h00);
    apb(8'h04, 1'b1, 8'h01);
    // clear when the next count would equal compare: counts 0..8
    gap(1'b1, 9, "cmp_clr");
    for (int i = 0; i < 3; i++)
    begin
      apb(8'h00, 1'b1, 8'h18);
      repeat (20) @(posedge clk_in);
      apb(8'h00, 1'b1, fz[i]);
      rcnt(c1);
      repeat (20) @(posedge clk_in);
      rcnt(c2);
      chk("frozen", c1, c2);
    end
    for (int i = 0; i < 2; i++)
    begin
      apb(8'h00, 1'b1, {3'b011, i[0], 4'h0});
      apb(8'h00, 1'b1, {3'b011, i[0], 4'h8});
      rcnt(c1);
      chk("run_zero", 32'h0, c1);
      pin.pulses(5 - 2 * i);
      repeat (4) @(posedge clk_in);
      rcnt(c1);
      chk("ext_cnt", 5 - 2 * i, c1);
    end
    apb(8'h18, 1'b1, 8'h07);
    for (int i = 0; i < 2; i++)
    begin
      apb(8'h04, 1'b1, {4'h0, i[0], 3'h0});
      apb(8'h00, 1'b1, 8'h10);
      apb(8'h00, 1'b1, 8'h19);
      repeat (3) @(posedge clk_in);
      chk("pin_a", i, pin_a_out);
      chk("pin_b", 1 - i, pin_b_out);
      chk("oe", 32'h3, {pin_b_oe_out, pin_a_oe_out});
    end
    apb(8'h04, 1'b1, 8'hc0);
    repeat (3) @(posedge clk_in);
    chk("oe_tmr", 32'h0, {pin_b_oe_out, pin_a_oe_out});
    // pwm, active high, duty from compare (9 counts of 128)
    apb(8'h04, 1'b1, 8'ha8);
    @(negedge clk_in);
    while (pin_a_out !== 1'b0)
      @(negedge clk_in);
    while (pin_a_out !== 1'b1)
      @(negedge clk_in);
    chk("pwm_b", 32'h0, pin_b_out);
    pw = 0;
    while (pin_a_out === 1'b1)
    begin
      pw++;
      @(negedge clk_in);
    end
    chk("pwm_duty", 9, pw);
    end_sim;
  end

  // hang guard, well past the longest expected run
  initial
  begin
    #1000000;
    err_total++;
    end_sim;
  end
endmodule

bind ctm_timer ctm_timer_checker u_chk (.*);

`default_nettype wire
